// [hw/tnm_node.sv]
// Purpose: send and receive mode control of a token network node
// Assumes: line frames arrive on clk; AXI4-Lite register access
// Notes: packet RAM is 32 pages of 16 words of 16 bits
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module tnm_node import tnm_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int ACK_WAIT = ACK_WAIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic token_valid,
  input wire logic [4:0] token_id,
  output logic token_pass,
  input wire logic rx_valid,
  input wire logic [1:0] rx_kind,
  input wire logic [7:0] rx_byte,
  input wire logic rx_last,
  input wire logic rx_err,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [1:0] tx_kind,
  output logic [7:0] tx_byte,
  output logic tx_last
);
  typedef enum logic [2:0] {
    T_IDLE, T_SEND_Q, T_WAIT1, T_SEND_D, T_WAIT2
  } tnm_tx_st_t;
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic transmit_mode_select;
    logic sshot;
    logic [4:0] nid;
    logic [31:0] rx_mode;
    logic [31:0] rx_flag;
    logic ta;
    logic ff_end;
    logic rx_errf;
    logic [8:0] ram_addr;
    logic tx_pend;
    tnm_tx_st_t tx_st;
    logic [11:0] wait_cnt;
    logic tok_pass;
    logic [4:0] rx_idx;
    logic [4:0] rx_page;
    logic [4:0] rx_did;
    logic rx_drop;
    logic ack_req;
    logic snd_start;
    logic [1:0] snd_kind;
  } tnm_state_t;

  tnm_state_t st;
  tnm_state_t next_st;
  tnm_frame_if f ();
  logic [15:0] ram [0:511];
  logic [15:0] hdr_word;
  logic [15:0] cpu_word;
  logic cpu_we;
  logic [15:0] cpu_wd;
  logic rx_we;
  logic rx_hi;
  logic [8:0] rx_waddr;
  logic [31:0] mode_rd;
  logic [31:0] stat_rd;
  logic tok_own;
  logic bcast;
  logic ack_seen;
  logic finish;
  logic data_end;

  // byte-enable merge of a write onto an old value
  function automatic logic [31:0] tnm_merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : tnm_merge

  // read ports of the packet RAM
  assign hdr_word = ram[{st.nid, 4'h0}];
  assign cpu_word = ram[st.ram_addr];
  assign f.rd_data = ram[f.rd_addr];
  assign bcast = (hdr_word[15:8] == 8'h00);
  assign tok_own = token_valid && (token_id == st.nid);
  assign ack_seen = rx_valid && rx_last && (rx_kind == KIND_ACK);

  // packet RAM writes, word from software, byte from the line
  always_ff @(posedge clk) begin
    if (cpu_we) begin
      ram[st.ram_addr] <= cpu_wd;
    end
    if (rx_we) begin
      if (rx_hi) begin
        ram[rx_waddr][15:8] <= rx_byte;
      end else begin
        ram[rx_waddr][7:0] <= rx_byte;
      end
    end
  end

  // register read images
  always_comb begin
    mode_rd = 32'h0;
    mode_rd[MODE_TXM] = st.transmit_mode_select;
    mode_rd[MODE_SSHOT] = st.sshot;
    mode_rd[MODE_NID_LSB +: 5] = st.nid;
    stat_rd = 32'h0;
    stat_rd[ST_TA] = st.ta;
    stat_rd[ST_FFEND] = st.ff_end;
    stat_rd[ST_RXERR] = st.rx_errf;
    stat_rd[ST_BUSY] = st.tx_pend;
  end

  // bus slave, transmit sequencer and receive path
  always_comb begin
    logic [31:0] v;
    logic [31:0] rxcmd;
    logic [3:0] w1c;
    logic tx_cmd;
    logic mon_clr;
    logic [4:0] pg;
    logic [4:0] destination_node_id;
    logic drop;
    v = 32'h0;
    rxcmd = 32'h0;
    w1c = 4'h0;
    tx_cmd = 1'b0;
    mon_clr = 1'b0;
    pg = 5'h00;
    destination_node_id = 5'h00;
    drop = 1'b0;
    next_st = st;
    next_st.tok_pass = 1'b0;
    next_st.snd_start = 1'b0;
    cpu_we = 1'b0;
    cpu_wd = 16'h0000;
    rx_we = 1'b0;
    rx_hi = 1'b0;
    rx_waddr = 9'h000;
    finish = 1'b0;
    data_end = 1'b0;
    // write address and data, taken in either order
    if (awready && awvalid) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = awaddr[7:0];
    end
    if (wready && wvalid) begin
      next_st.w_got = 1'b1;
      next_st.wdata = wdata;
      next_st.wstrb = wstrb;
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      case (st.aw_addr)
        OFF_MODE: begin
          v = tnm_merge(mode_rd, st.wdata, st.wstrb);
          next_st.transmit_mode_select = v[MODE_TXM];
          next_st.sshot = v[MODE_SSHOT];
          next_st.nid = v[MODE_NID_LSB +: 5];
        end
        OFF_RXMODE: begin
          v = tnm_merge(st.rx_mode, st.wdata, st.wstrb);
          next_st.rx_mode = v & RXMODE_MASK;
        end
        OFF_RXFLAG: rxcmd = tnm_merge(32'h0, st.wdata, st.wstrb);
        OFF_CMD: begin
          v = tnm_merge(32'h0, st.wdata, st.wstrb);
          tx_cmd = v[CMD_TX];
          mon_clr = v[CMD_MON];
        end
        OFF_STATUS: begin
          v = tnm_merge(32'h0, st.wdata, st.wstrb);
          w1c = v[3:0];
        end
        OFF_RAMADDR: begin
          v = tnm_merge({23'h0, st.ram_addr}, st.wdata, st.wstrb);
          next_st.ram_addr = v[8:0];
        end
        OFF_RAMDATA: begin
          v = tnm_merge({16'h0, cpu_word}, st.wdata, st.wstrb);
          cpu_we = 1'b1;
          cpu_wd = v[15:0];
        end
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    // read channel
    if (arready && arvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      case (araddr[7:0])
        OFF_MODE: next_st.rdata = mode_rd;
        OFF_RXMODE: next_st.rdata = st.rx_mode;
        OFF_RXFLAG: next_st.rdata = st.rx_flag & RXMODE_MASK;
        OFF_STATUS: next_st.rdata = stat_rd;
        OFF_RAMADDR: next_st.rdata = {23'h0, st.ram_addr};
        OFF_RAMDATA: next_st.rdata = {16'h0, cpu_word};
        OFF_CMD: next_st.rdata = 32'h0;
        default: begin
          next_st.rdata = 32'h0;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    // clears first so that a hardware set in the same cycle wins
    next_st.rx_flag = st.rx_flag & ~rxcmd & ~(mon_clr ? st.rx_mode : 32'h0);
    if (w1c[ST_FFEND]) begin
      next_st.ff_end = 1'b0;
    end
    if (w1c[ST_RXERR]) begin
      next_st.rx_errf = 1'b0;
    end
    // software alone starts a transmission
    if (tx_cmd && !st.tx_pend) begin
      next_st.ta = 1'b0;
      next_st.tx_pend = 1'b1;
    end
    // transmit sequencer, packets run from the own token, acks sent without it
    unique case (st.tx_st)
      T_IDLE: begin
        if (tok_own) begin
          if (st.tx_pend && !f.busy && !st.snd_start) begin
            next_st.snd_start = 1'b1;
            next_st.snd_kind = bcast ? KIND_DATA : KIND_QUERY;
            next_st.tx_st = bcast ? T_SEND_D : T_SEND_Q;
          end else begin
            next_st.tok_pass = 1'b1;
          end
        end else if (st.ack_req && !f.busy && !st.snd_start) begin
          next_st.snd_start = 1'b1;
          next_st.snd_kind = KIND_ACK;
          next_st.ack_req = 1'b0;
        end
      end
      T_SEND_Q: begin
        if (f.done) begin
          next_st.tx_st = T_WAIT1;
          next_st.wait_cnt = 12'h000;
        end
      end
      T_WAIT1: begin
        if (ack_seen) begin
          next_st.snd_start = 1'b1;
          next_st.snd_kind = KIND_DATA;
          next_st.tx_st = T_SEND_D;
        end else if (st.wait_cnt == 12'(ACK_WAIT - 1)) begin
          finish = 1'b1;
        end else begin
          next_st.wait_cnt = 12'(st.wait_cnt + 12'h001);
        end
      end
      T_SEND_D: begin
        if (f.done) begin
          if (bcast) begin
            finish = 1'b1;
          end else begin
            next_st.tx_st = T_WAIT2;
            next_st.wait_cnt = 12'h000;
          end
        end
      end
      T_WAIT2: begin
        if (ack_seen || st.wait_cnt == 12'(ACK_WAIT - 1)) begin
          finish = 1'b1;
        end else begin
          next_st.wait_cnt = 12'(st.wait_cnt + 12'h001);
        end
      end
    endcase
    // end of one packet: stop unless remote mode sends continuously
    if (finish) begin
      next_st.tx_st = T_IDLE;
      next_st.tok_pass = 1'b1;
      if (!st.transmit_mode_select || st.sshot) begin
        next_st.ta = 1'b1;
        next_st.tx_pend = 1'b0;
      end
    end
    // receive path: every query and data frame on the line
    if (rx_valid && (rx_kind == KIND_DATA || rx_kind == KIND_QUERY)) begin
      pg = (st.rx_idx == IDX_SID) ? rx_byte[4:0] : st.rx_page;
      drop = (st.rx_idx == IDX_SID)
           ? (!st.rx_mode[rx_byte[4:0]] && st.rx_flag[rx_byte[4:0]])
           : st.rx_drop;
      destination_node_id = (st.rx_idx == IDX_DID) ? rx_byte[4:0] : st.rx_did;
      next_st.rx_page = pg;
      next_st.rx_drop = drop;
      next_st.rx_did = destination_node_id;
      next_st.rx_idx = tnm_step(st.rx_idx, rx_byte);
      if (rx_kind == KIND_DATA && !drop) begin
        rx_we = 1'b1;
        rx_waddr = {pg, st.rx_idx[4:1]};
        rx_hi = st.rx_idx[0];
      end
      if (rx_last) begin
        next_st.rx_idx = IDX_SID;
        if (drop) begin
          next_st.rx_errf = 1'b1;
        end else if (!rx_err) begin
          if (destination_node_id == st.nid && destination_node_id != 5'h00) begin
            next_st.ack_req = 1'b1;
          end
          if (rx_kind == KIND_DATA) begin
            data_end = 1'b1;
            next_st.rx_flag[pg] = 1'b1;
            if (!st.rx_mode[pg]) begin
              next_st.ff_end = 1'b1;
            end
          end
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.ta <= 1'b1;
      st.sshot <= 1'b0;
      st.rx_flag <= RXFLAG_RST;
      st.nid <= NID_RST;
    end else begin
      st <= next_st;
    end
  end

  // sender hookup and port drive
  assign f.start = st.snd_start;
  assign f.kind = st.snd_kind;
  assign f.page = st.nid;
  assign f.ack_id = st.nid;
  assign f.tx_ready = tx_ready;
  assign tx_valid = f.tx_valid;
  assign tx_kind = f.tx_kind;
  assign tx_byte = f.tx_byte;
  assign tx_last = f.tx_last;
  assign token_pass = st.tok_pass;
  assign awready = !st.aw_got && !st.bvalid;
  assign wready = !st.w_got && !st.bvalid;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = !st.rvalid;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;

  tnm_frame_tx u_frame_tx (
    .clk(clk),
    .rst_n(rst_n),
    .f(f.snd)
  );

  sequence s_own_query_end;
    rx_valid && rx_last && rx_kind == KIND_QUERY && !rx_err
      && rx_byte[4:0] == st.nid && rx_byte[4:0] != 5'h00
      && !(!st.rx_mode[st.rx_page] && st.rx_flag[st.rx_page]);
  endsequence
  sequence s_ack_start;
    ##[1:8] (st.snd_start && st.snd_kind == KIND_ACK);
  endsequence

  a_tx_on_token: assert property (@(posedge clk) disable iff (!rst_n)
    st.tx_st == T_IDLE && next_st.tx_st != T_IDLE |-> tok_own && st.tx_pend)
    else $error("transmission without own token");
  a_cmd_clears_ta: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(st.tx_pend) |-> !st.ta && !$past(st.tx_pend))
    else $error("available flag not cleared by command");
  a_bcast_no_query: assert property (@(posedge clk) disable iff (!rst_n)
    tx_valid && tx_kind == KIND_QUERY |-> !bcast)
    else $error("query sent for broadcast");
  a_shot_returns_ta: assert property (
    @(posedge clk) disable iff (!rst_n)
    finish && (!st.transmit_mode_select || st.sshot) |=> st.ta && !st.tx_pend)
    else $error("available flag not returned");
  a_cont_holds_ta: assert property (@(posedge clk) disable iff (!rst_n)
    finish && st.transmit_mode_select && !st.sshot |=> !st.ta && st.tx_pend)
    else $error("continuous send stopped");
  a_shot_reset: assert property (@(posedge clk)
    !$past(rst_n) |-> !st.sshot)
    else $error("single-shot bit not zero after reset");
  a_own_ack: assert property (@(posedge clk) disable iff (!rst_n)
    s_own_query_end ##1 (st.tx_st == T_IDLE && !f.busy && !token_valid)
      |-> s_ack_start)
    else $error("own query not answered in time");
  a_query_acked: assert property (@(posedge clk) disable iff (!rst_n)
    s_own_query_end |=> st.ack_req || st.snd_kind == KIND_ACK)
    else $error("own query not answered");
  a_drop_error: assert property (@(posedge clk) disable iff (!rst_n)
    rx_valid && rx_last && rx_kind == KIND_DATA && st.rx_drop
      && st.rx_idx != IDX_SID |-> !rx_we ##1 st.rx_errf)
    else $error("dropped packet not flagged");
  a_flag_on_end: assert property (@(posedge clk) disable iff (!rst_n)
    data_end |=> st.rx_flag[$past(next_st.rx_page)])
    else $error("receive flag not set at end");
  a_remote_store: assert property (@(posedge clk) disable iff (!rst_n)
    rx_valid && rx_kind == KIND_DATA && st.rx_idx != IDX_SID
      && st.rx_mode[st.rx_page] |-> rx_we)
    else $error("remote page not written");
endmodule : tnm_node

// [hw/tnm_pkg.sv]
// Purpose: shared constants for the token network node
// Assumes: 32-byte pages, 32 pages, 16-bit packet RAM words
// Notes: byte offsets are AXI4-Lite byte addresses
package tnm_pkg;
  // clock and acknowledge wait
  localparam int CLK_NS = 40;
  localparam int ACK_WAIT_NS = 4000;
  localparam int ACK_WAIT_CYC = (ACK_WAIT_NS + CLK_NS - 1) / CLK_NS;
  // register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_RXMODE = 8'h04;
  localparam logic [7:0] OFF_RXFLAG = 8'h08;
  localparam logic [7:0] OFF_CMD = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_RAMADDR = 8'h14;
  localparam logic [7:0] OFF_RAMDATA = 8'h18;
  // field positions
  localparam int MODE_TXM = 0;
  localparam int MODE_SSHOT = 1;
  localparam int MODE_NID_LSB = 8;
  localparam int CMD_TX = 0;
  localparam int CMD_MON = 1;
  localparam int ST_TA = 0;
  localparam int ST_FFEND = 1;
  localparam int ST_RXERR = 2;
  localparam int ST_BUSY = 3;
  // reset values and receive mode mask
  localparam logic [31:0] RXFLAG_RST = 32'hFFFFFFFF;
  localparam logic [31:0] RXMODE_MASK = 32'hFFFFFFFE;
  localparam logic [4:0] NID_RST = 5'h01;
  // packet header positions, data start minimum and last page byte
  localparam logic [4:0] IDX_SID = 5'h00;
  localparam logic [4:0] IDX_DID = 5'h01;
  localparam logic [4:0] IDX_CP = 5'h02;
  localparam logic [4:0] CP_MIN = 5'h03;
  localparam logic [4:0] PAGE_LAST = 5'h1F;
  // frame kinds on the line
  localparam logic [1:0] KIND_QUERY = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;
  localparam logic [1:0] KIND_ACK = 2'h3;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // next byte position: after the pointer byte jump to the data start
  function automatic logic [4:0] tnm_step(input logic [4:0] idx,
                                          input logic [7:0] b);
    logic [4:0] cp;
    cp = (b[7:5] != 3'h0 || b[4:0] < CP_MIN) ? CP_MIN : b[4:0];
    return (idx == IDX_CP) ? cp : 5'(idx + 5'h01);
  endfunction : tnm_step
endpackage : tnm_pkg

// [hw/tnm_frame_if.sv]
// Purpose: link between node control and frame sender
// Assumes: one clock domain
// Notes: sender reads packet RAM through rd_addr and rd_data
`timescale 1ns/10ps
interface tnm_frame_if;
  logic start;
  logic [1:0] kind;
  logic [4:0] page;
  logic [4:0] ack_id;
  logic busy;
  logic done;
  logic [8:0] rd_addr;
  logic [15:0] rd_data;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] tx_byte;
  logic tx_last;
  logic [1:0] tx_kind;
  modport snd (input start, kind, page, ack_id, rd_data, tx_ready,
               output busy, done, rd_addr, tx_valid, tx_byte, tx_last,
               tx_kind);
  modport ctl (output start, kind, page, ack_id, rd_data, tx_ready,
               input busy, done, rd_addr, tx_valid, tx_byte, tx_last,
               tx_kind);
endinterface : tnm_frame_if

// [hw/tnm_frame_tx.sv]
// Purpose: serialises query, data and acknowledge frames
// Assumes: RAM read is combinational from rd_addr
// Notes: at least two cycles per byte, one to load and one or more to offer until tx_ready
`timescale 1ns/10ps
module tnm_frame_tx import tnm_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  tnm_frame_if.snd f
);
  typedef enum logic [1:0] {S_IDLE, S_LOAD, S_SEND} tnm_snd_st_t;
  typedef struct packed {
    tnm_snd_st_t st;
    logic [4:0] idx;
    logic [1:0] kind;
    logic [4:0] page;
    logic [4:0] ack_id;
    logic [7:0] tx_byte;
    logic last;
    logic valid;
    logic done;
  } tnm_snd_t;
  tnm_snd_t s;
  tnm_snd_t next_s;
  logic [7:0] rd_byte;

  // byte lane of the addressed word
  assign f.rd_addr = {s.page, s.idx[4:1]};
  assign rd_byte = s.idx[0] ? f.rd_data[15:8] : f.rd_data[7:0];

  // load, offer, advance
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    unique case (s.st)
      S_IDLE: begin
        if (f.start) begin
          next_s.st = S_LOAD;
          next_s.idx = IDX_SID;
          next_s.kind = f.kind;
          next_s.page = f.page;
          next_s.ack_id = f.ack_id;
        end
      end
      S_LOAD: begin
        next_s.tx_byte = (s.kind == KIND_ACK) ? {3'h0, s.ack_id} : rd_byte;
        next_s.last = (s.kind == KIND_ACK)
                   || (s.kind == KIND_QUERY && s.idx == IDX_DID)
                   || (s.kind == KIND_DATA && s.idx == PAGE_LAST);
        next_s.valid = 1'b1;
        next_s.st = S_SEND;
      end
      S_SEND: begin
        if (f.tx_ready) begin
          next_s.valid = 1'b0;
          if (s.last) begin
            next_s.done = 1'b1;
            next_s.st = S_IDLE;
          end else begin
            next_s.idx = tnm_step(s.idx, s.tx_byte);
            next_s.st = S_LOAD;
          end
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign f.busy = (s.st != S_IDLE);
  assign f.done = s.done;
  assign f.tx_valid = s.valid;
  assign f.tx_byte = s.tx_byte;
  assign f.tx_last = s.last;
  assign f.tx_kind = s.kind;

  a_tx_hold: assert property (@(posedge clk) disable iff (!rst_n)
    f.tx_valid && !f.tx_ready |=> f.tx_valid && $stable(f.tx_byte))
    else $error("frame byte dropped before taken");
endmodule : tnm_frame_tx

// [tb/tnm_peer.sv]
// Purpose: other nodes on the line
// Assumes: line bytes move on clk
// Notes: acks frames sent to a nonzero node
`timescale 1ns/10ps
module tnm_peer import tnm_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  output logic rx_valid,
  output logic [1:0] rx_kind,
  output logic [7:0] rx_byte,
  output logic rx_last,
  output logic rx_err,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [1:0] tx_kind,
  input wire logic [7:0] tx_byte,
  input wire logic tx_last
);
  logic [11:0] sendq[$];
  logic [9:0] got[$];
  logic [7:0] destination_node_id;
  logic [5:0] nb = 6'h00;
  logic stall = 1'b0;
  logic [1:0] hold = 2'h0;
  // queue a frame, last flag on its final byte
  task automatic frame(input logic [1:0] k, input logic [7:0] b[$]);
    foreach (b[i]) sendq.push_back({1'b0, i == b.size() - 1, k, b[i]});
  endtask : frame
  // take sent bytes, answer with ack, play queued bytes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      tx_ready <= 1'b0;
      {rx_err, rx_last, rx_kind, rx_byte} <= 12'h000;
    end else begin
      stall <= ~stall;
      tx_ready <= tx_valid && !tx_ready && (!slow || stall);
      if (tx_valid && tx_ready) begin
        got.push_back({tx_kind, tx_byte});
        if (nb == 6'h01) destination_node_id = tx_byte;
        nb = tx_last ? 6'h00 : nb + 6'h01;
        if (tx_last && tx_kind != KIND_ACK && destination_node_id != 8'h00) begin
          sendq.push_back({2'b01, KIND_ACK, 8'h02});
          hold = 2'h3;
        end
      end
      // answer only once the sender has closed its frame
      if (hold != 2'h0) hold = hold - 2'h1;
      rx_valid <= sendq.size() > 0 && hold == 2'h0;
      // idle line shows changing bytes
      if (sendq.size() > 0 && hold == 2'h0)
        {rx_err, rx_last, rx_kind, rx_byte} <= sendq.pop_front();
      else rx_byte <= ~rx_byte;
    end
  end
endmodule : tnm_peer

// [tb/testbench.sv]
// Purpose: self-checking bench for the node
// Assumes: peer model plays the line
// Notes: ack wait cut to 8 cycles
`timescale 1ns/10ps
module testbench import tnm_pkg::*; ;
  logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic token_valid = 1'b0;
  logic [4:0] token_id = 5'h00;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rx_byte, tx_byte;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp, rx_kind, tx_kind, rsp;
  logic awready, wready, bvalid, arready, rvalid, token_pass;
  logic rx_valid, rx_last, rx_err, tx_valid, tx_ready, tx_last;
  int seed = 32'h3E39;
  int fails = 0;
  int tests_run = 0;
  tnm_node #(.ACK_WAIT(8)) i_dut (.clk, .rst_n, .awaddr, .awvalid,
    .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid,
    .bready(1'b1), .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready(1'b1), .token_valid, .token_id, .token_pass, .rx_valid,
    .rx_kind, .rx_byte, .rx_last, .rx_err, .tx_valid, .tx_ready,
    .tx_kind, .tx_byte, .tx_last);
  tnm_peer i_peer (.clk, .rst_n, .slow, .rx_valid, .rx_kind, .rx_byte,
    .rx_last, .rx_err, .tx_valid, .tx_ready, .tx_kind, .tx_byte, .tx_last);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rsp = rresp;
    chk(rdata, e);
  endtask : rc
  task automatic put(input logic [8:0] a, input logic [15:0] v);
    wr(OFF_RAMADDR, {23'h0, a});
    wr(OFF_RAMDATA, {16'h0, v});
  endtask : put
  // own page one: header, pointer 32-4, four data bytes
  task automatic load(input logic [7:0] destination_node_id, input logic [31:0] v);
    put(9'h010, {destination_node_id, 8'h01});
    put(9'h011, 16'h001C);
    put(9'h01E, v[15:0]);
    put(9'h01F, v[31:16]);
  endtask : load
  // hand our token over and wait for it to be passed on
  task automatic send_wait;
    int n;
    n = 0;
    token_id <= 5'h01;
    token_valid <= 1'b1;
    @(posedge clk);
    token_valid <= 1'b0;
    while (!token_pass && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n < 3000), 32'h1);
    repeat (4) @(posedge clk);
  endtask : send_wait
  task automatic chk_tx(input logic [7:0] destination_node_id, input logic [31:0] v);
    logic [9:0] e[$];
    e = {};
    if (destination_node_id != 8'h00) e = '{{KIND_QUERY, 8'h01}, {KIND_QUERY, destination_node_id}};
    e.push_back({KIND_DATA, 8'h01});
    e.push_back({KIND_DATA, destination_node_id});
    e.push_back({KIND_DATA, 8'h1C});
    for (int i = 0; i < 4; i++) e.push_back({KIND_DATA, v[8*i +: 8]});
    chk(32'(i_peer.got.size()), 32'(e.size()));
    foreach (e[i]) chk(32'(i_peer.got[i]), 32'(e[i]));
    i_peer.got.delete();
  endtask : chk_tx
  task automatic chk_ack(input int n);
    repeat (60) @(posedge clk);
    chk(32'(i_peer.got.size()), 32'(n));
    foreach (i_peer.got[i]) chk(32'(i_peer.got[i]), 32'h000003_01);
    i_peer.got.delete();
  endtask : chk_ack
  initial forever #20 clk = ~clk;
  // watchdog for a hung handshake
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rc(OFF_MODE, 32'h00000100);
    rc(OFF_STATUS, 32'h00000001);
    rc(OFF_RXFLAG, 32'hFFFFFFFE);
    rc(OFF_RXMODE, 32'h00000000);
    rc(8'h40, 32'h00000000);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    $display("reset test done");
    d = $random(seed);
    load(8'h02, d);
    send_wait();
    chk_ack(0);
    wr(OFF_CMD, 32'h1);
    rc(OFF_STATUS, 32'h00000008);
    chk_ack(0);
    slow <= 1'b1;
    send_wait();
    chk_tx(8'h02, d);
    rc(OFF_STATUS, 32'h00000001);
    $display("free send test done");
    d = $random(seed);
    load(8'h00, d);
    wr(OFF_MODE, 32'h00000101);
    wr(OFF_CMD, 32'h1);
    repeat (2) begin
      send_wait();
      chk_tx(8'h00, d);
      rc(OFF_STATUS, 32'h00000008);
    end
    wr(OFF_MODE, 32'h00000103);
    for (int i = 0; i < 2; i++) begin
      if (i > 0) wr(OFF_CMD, 32'h1);
      send_wait();
      chk_tx(8'h00, d);
      rc(OFF_STATUS, 32'h00000001);
      send_wait();
      chk_ack(0);
    end
    $display("remote send test done");
    wr(OFF_RXFLAG, 32'h00000008);
    rc(OFF_RXFLAG, 32'hFFFFFFF6);
    d = $random(seed);
    i_peer.frame(KIND_QUERY, '{8'h03, 8'h01});
    chk_ack(1);
    i_peer.frame(KIND_DATA, '{8'h03, 8'h01, 8'h1E, d[7:0], d[15:8]});
    chk_ack(1);
    rc(OFF_RXFLAG, 32'hFFFFFFFE);
    rc(OFF_STATUS, 32'h00000003);
    wr(OFF_RAMADDR, 32'h0000003F);
    rc(OFF_RAMDATA, {16'h0, d[15:0]});
    i_peer.frame(KIND_DATA, '{8'h03, 8'h01, 8'h1E, ~d[7:0], d[31:24]});
    chk_ack(0);
    rc(OFF_STATUS, 32'h00000007);
    rc(OFF_RAMDATA, {16'h0, d[15:0]});
    wr(OFF_RXMODE, 32'h00000010);
    rc(OFF_RXMODE, 32'h00000010);
    wr(OFF_CMD, 32'h2);
    rc(OFF_RXFLAG, 32'hFFFFFFEE);
    wr(OFF_RAMADDR, 32'h0000004F);
    repeat (2) begin
      d = $random(seed);
      i_peer.frame(KIND_DATA, '{8'h04, 8'h09, 8'h1E, d[7:0], d[15:8]});
      chk_ack(0);
      rc(OFF_RAMDATA, {16'h0, d[15:0]});
    end
    rc(OFF_RXFLAG, 32'hFFFFFFFE);
    $display("receive test done");
    end_sim();
  end
endmodule : testbench
